// ### dei_irq_top.sv
// Error flag aggregator with AXI4-Lite registers and interrupt pin
//
// Functional notes
// (RL1) Global enable off: interrupt pin floats.
// (RL2) Enabled: pin high on set, unmasked flag.
// (RL3) Enabled, nothing pending: pin driven low.
// (RL4) Per-source mask bits gate channel flags.
// (RL5) Channel A mask bit 0 gates lock loss.
// (RL6) Same bit layout for both channel registers.
// (RL7) Sync fault sets bit 7.
// (RL8) Checksum fault sets bit 6.
// (RL9) Uncorrectable header fault sets bit 5.
// (RL10) Corrected header fault sets bit 4.
// (RL11) Low-level protocol fault sets bit 3.
// (RL12) Leader sequence fault sets bit 2.
// (RL13) Lock loss sets bit 0; resets set.
// (RL14) Flags hold until host writes one.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module dei_irq_top (
    input  wire logic                    clk_in,
    input  wire logic                    sys_rst_in,
    input  wire logic [dei_pkg::ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                    s_axi_awvalid_in,
    output logic                         s_axi_awready_out,
    input  wire logic [dei_pkg::DATA_W-1:0] s_axi_wdata_in,
    input  wire logic [3:0]              s_axi_wstrb_in,
    input  wire logic                    s_axi_wvalid_in,
    output logic                         s_axi_wready_out,
    output logic [1:0]                   s_axi_bresp_out,
    output logic                         s_axi_bvalid_out,
    input  wire logic                    s_axi_bready_in,
    input  wire logic [dei_pkg::ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                    s_axi_arvalid_in,
    output logic                         s_axi_arready_out,
    output logic [dei_pkg::DATA_W-1:0]   s_axi_rdata_out,
    output logic [1:0]                   s_axi_rresp_out,
    output logic                         s_axi_rvalid_out,
    input  wire logic                    s_axi_rready_in,
    input  wire logic                    chan_a_sync_fault_in,
    input  wire logic                    chan_a_checksum_fault_in,
    input  wire logic                    chan_a_uncorrectable_header_fault_in,
    input  wire logic                    chan_a_corrected_header_fault_in,
    input  wire logic                    chan_a_protocol_fault_in,
    input  wire logic                    chan_a_leader_fault_in,
    input  wire logic                    chan_b_sync_fault_in,
    input  wire logic                    chan_b_checksum_fault_in,
    input  wire logic                    chan_b_uncorrectable_header_fault_in,
    input  wire logic                    chan_b_corrected_header_fault_in,
    input  wire logic                    chan_b_protocol_fault_in,
    input  wire logic                    chan_b_leader_fault_in,
    input  wire logic                    pll_lock_in,
    output logic                         irq_out,
    output logic                         irq_oe_out
);
    import dei_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_held_reg;
    logic              aw_held_next;
    logic              awready_reg;
    logic [REG_W-1:0]  w_data_reg;
    logic              w_lane_reg;
    logic              w_held_reg;
    logic              w_held_next;
    logic              wready_reg;
    logic              bvalid_reg;
    logic              bvalid_next;
    logic [1:0]        bresp_reg;
    logic              arready_reg;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic [REG_W-1:0]  rdata_reg;
    logic [1:0]        rresp_reg;

    logic [REG_W-1:0]  ctrl_reg;
    logic [REG_W-1:0]  ctrl_next;
    logic [REG_W-1:0]  mask_a_reg;
    logic [REG_W-1:0]  mask_a_next;
    logic [REG_W-1:0]  mask_b_reg;
    logic [REG_W-1:0]  mask_b_next;
    logic              irq_reg;
    logic              irq_oe_reg;

    logic              lock_meta_reg;
    logic              lock_sync_reg;
    logic              lock_prev_reg;

    wire logic              aw_take;
    wire logic              w_take;
    wire logic              wr_fire;
    wire logic              ar_take;
    wire logic              wr_ctrl;
    wire logic              wr_mask_a;
    wire logic              wr_mask_b;
    wire logic              wr_flags_a;
    wire logic              wr_flags_b;
    wire logic              wr_mapped;
    wire logic              rd_mapped;
    wire logic [REG_W-1:0]  rd_mux;
    wire logic [REG_W-1:0]  clr_a;
    wire logic [REG_W-1:0]  clr_b;
    wire logic [REG_W-1:0]  flags_a;
    wire logic [REG_W-1:0]  flags_b;
    wire logic [FAULT_N-1:0] fault_a;
    wire logic [FAULT_N-1:0] fault_b;
    wire logic              lock_drop;
    wire logic              pending;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite handshakes

    assign aw_take  = s_axi_awvalid_in & awready_reg;
    assign w_take   = s_axi_wvalid_in & wready_reg;
    // Response must drain before the next write takes effect
    assign wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign ar_take  = s_axi_arvalid_in & arready_reg;

    assign aw_held_next = aw_take | (aw_held_reg & ~wr_fire);
    assign w_held_next  = w_take | (w_held_reg & ~wr_fire);
    assign bvalid_next  = wr_fire | (bvalid_reg & ~s_axi_bready_in);
    assign rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready_in);

    assign wr_ctrl    = wr_fire & w_lane_reg & (aw_addr_reg == ADDR_IRQ_CTRL);
    assign wr_mask_a  = wr_fire & w_lane_reg &
                        (aw_addr_reg == ADDR_CHAN_A_MASK);
    assign wr_mask_b  = wr_fire & w_lane_reg &
                        (aw_addr_reg == ADDR_CHAN_B_MASK);
    assign wr_flags_a = wr_fire & w_lane_reg &
                        (aw_addr_reg == ADDR_CHAN_A_FLAGS);
    assign wr_flags_b = wr_fire & w_lane_reg &
                        (aw_addr_reg == ADDR_CHAN_B_FLAGS);
    assign wr_mapped  = (aw_addr_reg == ADDR_IRQ_CTRL) |
                        (aw_addr_reg == ADDR_CHAN_A_MASK) |
                        (aw_addr_reg == ADDR_CHAN_B_MASK) |
                        (aw_addr_reg == ADDR_CHAN_A_FLAGS) |
                        (aw_addr_reg == ADDR_CHAN_B_FLAGS);

    assign rd_mapped = (s_axi_araddr_in == ADDR_IRQ_CTRL) |
                       (s_axi_araddr_in == ADDR_CHAN_A_MASK) |
                       (s_axi_araddr_in == ADDR_CHAN_B_MASK) |
                       (s_axi_araddr_in == ADDR_CHAN_A_FLAGS) |
                       (s_axi_araddr_in == ADDR_CHAN_B_FLAGS);
    // RL6 same layout readback
    assign rd_mux =
        (s_axi_araddr_in == ADDR_IRQ_CTRL)     ? ctrl_reg   :
        (s_axi_araddr_in == ADDR_CHAN_A_MASK)  ? mask_a_reg :
        (s_axi_araddr_in == ADDR_CHAN_B_MASK)  ? mask_b_reg :
        (s_axi_araddr_in == ADDR_CHAN_A_FLAGS) ? flags_a    :
        (s_axi_araddr_in == ADDR_CHAN_B_FLAGS) ? flags_b    : '0;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_held_reg <= 1'h0;
            awready_reg <= 1'h0;
            w_held_reg  <= 1'h0;
            wready_reg  <= 1'h0;
            bvalid_reg  <= 1'h0;
            arready_reg <= 1'h0;
            rvalid_reg  <= 1'h0;
        end else begin
            aw_held_reg <= aw_held_next;
            awready_reg <= ~aw_held_next;
            w_held_reg  <= w_held_next;
            wready_reg  <= ~w_held_next;
            bvalid_reg  <= bvalid_next;
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_lane_reg  <= 1'h0;
            bresp_reg   <= RESP_OKAY;
            rdata_reg   <= '0;
            rresp_reg   <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr_in;
            end
            // Registers are one byte wide; only lane 0 matters
            if (w_take) begin
                w_data_reg <= s_axi_wdata_in[REG_W-1:0];
                w_lane_reg <= s_axi_wstrb_in[0];
            end
            if (wr_fire) begin
                bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            if (ar_take) begin
                rdata_reg <= rd_mux;
                rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out  = wready_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rresp_out   = rresp_reg;
    assign s_axi_rdata_out   = {{(DATA_W-REG_W){1'h0}}, rdata_reg};

    ////////////////////////////////////////////////////////////////////////
    // Control and mask registers

    // RL4 writable mask bits
    assign ctrl_next   = wr_ctrl ? (w_data_reg & CTRL_WMASK) : ctrl_reg;
    assign mask_a_next = wr_mask_a ? (w_data_reg & MASK_A_WMASK) : mask_a_reg;
    assign mask_b_next = wr_mask_b ? (w_data_reg & MASK_B_WMASK) : mask_b_reg;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_reg   <= CTRL_RESET;
            mask_a_reg <= MASK_RESET;
            mask_b_reg <= MASK_RESET;
        end else begin
            ctrl_reg   <= ctrl_next;
            mask_a_reg <= mask_a_next;
            mask_b_reg <= mask_b_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags

    // RL14 write one clears
    assign clr_a = wr_flags_a ? w_data_reg : '0;
    assign clr_b = wr_flags_b ? w_data_reg : '0;

    // RL7 to RL12 fault inputs placed from bit 2 upward
    assign fault_a = {chan_a_sync_fault_in, chan_a_checksum_fault_in,
                      chan_a_uncorrectable_header_fault_in,
                      chan_a_corrected_header_fault_in,
                      chan_a_protocol_fault_in, chan_a_leader_fault_in};
    assign fault_b = {chan_b_sync_fault_in, chan_b_checksum_fault_in,
                      chan_b_uncorrectable_header_fault_in,
                      chan_b_corrected_header_fault_in,
                      chan_b_protocol_fault_in, chan_b_leader_fault_in};

    // RL6 one layout, both channels
    genvar g;
    generate
        for (g = 0; g < FAULT_N; g = g + 1) begin : g_fault
            dei_flag_bit #(
                .RESET_VAL (FAULT_FLAG_RESET)
            ) u_flag_a (
                .clk_in     (clk_in),
                .sys_rst_in (sys_rst_in),
                .set_in     (fault_a[g]),
                .clr_in     (clr_a[g+FAULT_LO]),
                .flag_out   (flags_a[g+FAULT_LO])
            );
            dei_flag_bit #(
                .RESET_VAL (FAULT_FLAG_RESET)
            ) u_flag_b (
                .clk_in     (clk_in),
                .sys_rst_in (sys_rst_in),
                .set_in     (fault_b[g]),
                .clr_in     (clr_b[g+FAULT_LO]),
                .flag_out   (flags_b[g+FAULT_LO])
            );
        end
    endgenerate

    // Lock status comes from the PLL domain, so synchronise it first
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            lock_meta_reg <= 1'h0;
            lock_sync_reg <= 1'h0;
            lock_prev_reg <= 1'h0;
        end else begin
            lock_meta_reg <= pll_lock_in;
            lock_sync_reg <= lock_meta_reg;
            lock_prev_reg <= lock_sync_reg;
        end
    end

    // RL13 locked to unlocked edge
    assign lock_drop = lock_prev_reg & ~lock_sync_reg;

    dei_flag_bit #(
        .RESET_VAL (PLL_FLAG_RESET)
    ) u_flag_pll (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (lock_drop),
        .clr_in     (clr_a[PLL_BIT]),
        .flag_out   (flags_a[PLL_BIT])
    );

    // Unused bits read as zero
    assign flags_a[FAULT_LO-1]           = 1'h0;
    assign flags_b[FAULT_LO-1:0]         = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt pin

    // RL2 RL4 RL5 masked combine
    assign pending = (|(flags_a & mask_a_reg)) | (|(flags_b & mask_b_reg));

    // RL1 RL3 enable drives or floats
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_reg    <= 1'h0;
            irq_oe_reg <= 1'h0;
        end else begin
            irq_reg    <= ctrl_reg[IRQ_EN_BIT] & pending;
            irq_oe_reg <= ctrl_reg[IRQ_EN_BIT];
        end
    end

    assign irq_out    = irq_reg;
    assign irq_oe_out = irq_oe_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_flag_a_idle(int b);
        !clr_a[b] ##0 flags_a[b];
    endsequence

    property p_float_when_off;
        @(posedge clk_in) disable iff (sys_rst_in)
        !ctrl_reg[IRQ_EN_BIT] |=> !irq_oe_out && !irq_out;
    endproperty
    a_float_when_off: assert property (p_float_when_off) // RL1
        else $error("pin driven while global enable is off");

    property p_high_on_pending;
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_reg[IRQ_EN_BIT] && pending |=> irq_oe_out && irq_out;
    endproperty
    a_high_on_pending: assert property (p_high_on_pending) // RL2
        else $error("pin not high with an enabled flag set");

    property p_low_when_quiet;
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_reg[IRQ_EN_BIT] && !pending |=> irq_oe_out && !irq_out;
    endproperty
    a_low_when_quiet: assert property (p_low_when_quiet) // RL3
        else $error("pin not driven low when nothing pending");

    property p_mask_blocks;
        @(posedge clk_in) disable iff (sys_rst_in)
        (flags_b != '0) && (mask_b_reg == '0) &&
        ((flags_a & mask_a_reg) == '0) |=> !irq_out;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) // RL4
        else $error("masked flag reached the pin");

    property p_lock_gate;
        @(posedge clk_in) disable iff (sys_rst_in)
        ctrl_reg[IRQ_EN_BIT] && (flags_a == 8'h01) && (mask_b_reg == '0)
        |=> irq_out == $past(mask_a_reg[PLL_BIT]);
    endproperty
    a_lock_gate: assert property (p_lock_gate) // RL5
        else $error("lock loss gating wrong");

    property p_read_b;
        @(posedge clk_in) disable iff (sys_rst_in)
        ar_take && (s_axi_araddr_in == ADDR_CHAN_B_FLAGS)
        |=> s_axi_rvalid_out && (s_axi_rdata_out[REG_W-1:0] == $past(flags_b));
    endproperty
    a_read_b: assert property (p_read_b) // RL6
        else $error("channel B flag readback wrong");

    property p_fault_sets(logic ev_a, logic ev_b, int b);
        @(posedge clk_in) disable iff (sys_rst_in)
        (ev_a |=> flags_a[b]) and (ev_b |=> flags_b[b]);
    endproperty
    a_sync_sets: assert property (p_fault_sets(chan_a_sync_fault_in,
        chan_b_sync_fault_in, SYNC_BIT)) // RL7
        else $error("sync fault not recorded");
    a_checksum_sets: assert property (p_fault_sets(chan_a_checksum_fault_in,
        chan_b_checksum_fault_in, CHECKSUM_BIT)) // RL8
        else $error("checksum fault not recorded");
    a_uncorr_sets: assert property (p_fault_sets(
        chan_a_uncorrectable_header_fault_in,
        chan_b_uncorrectable_header_fault_in, UNCORR_BIT)) // RL9
        else $error("uncorrectable header fault not recorded");
    a_corr_sets: assert property (p_fault_sets(
        chan_a_corrected_header_fault_in,
        chan_b_corrected_header_fault_in, CORR_BIT)) // RL10
        else $error("corrected header fault not recorded");
    a_protocol_sets: assert property (p_fault_sets(chan_a_protocol_fault_in,
        chan_b_protocol_fault_in, PROTOCOL_BIT)) // RL11
        else $error("protocol fault not recorded");
    a_leader_sets: assert property (p_fault_sets(chan_a_leader_fault_in,
        chan_b_leader_fault_in, LEADER_BIT)) // RL12
        else $error("leader fault not recorded");

    property p_lock_loss;
        @(posedge clk_in) disable iff (sys_rst_in)
        $fell(lock_sync_reg) |=> flags_a[PLL_BIT];
    endproperty
    a_lock_loss: assert property (p_lock_loss) // RL13
        else $error("lock loss not recorded");

    property p_sticky_clear;
        @(posedge clk_in) disable iff (sys_rst_in)
        (s_flag_a_idle(SYNC_BIT) |=> flags_a[SYNC_BIT]) and
        (clr_a[SYNC_BIT] && !chan_a_sync_fault_in |=> !flags_a[SYNC_BIT]);
    endproperty
    a_sticky_clear: assert property (p_sticky_clear) // RL14
        else $error("flag not sticky or not cleared by one");

endmodule // dei_irq_top

// ### dei_pkg.sv
// Constants for the error interrupt aggregator
package dei_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_IRQ_CTRL      = 8'he0;
    localparam logic [7:0]  IDX_CHAN_A_MASK   = 8'he1;
    localparam logic [7:0]  IDX_CHAN_B_MASK   = 8'he2;
    localparam logic [7:0]  IDX_CHAN_A_FLAGS  = 8'he5;
    localparam logic [7:0]  IDX_CHAN_B_FLAGS  = 8'he6;

    localparam int unsigned ADDR_W            = 12;
    localparam int unsigned DATA_W            = 32;
    localparam int unsigned REG_W             = 8;

    localparam logic [11:0] ADDR_IRQ_CTRL     = {2'h0, IDX_IRQ_CTRL, 2'h0};
    localparam logic [11:0] ADDR_CHAN_A_MASK  = {2'h0, IDX_CHAN_A_MASK, 2'h0};
    localparam logic [11:0] ADDR_CHAN_B_MASK  = {2'h0, IDX_CHAN_B_MASK, 2'h0};
    localparam logic [11:0] ADDR_CHAN_A_FLAGS = {2'h0, IDX_CHAN_A_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_CHAN_B_FLAGS = {2'h0, IDX_CHAN_B_FLAGS, 2'h0};

    // Field positions
    localparam int unsigned IRQ_EN_BIT        = 0;
    localparam int unsigned PLL_BIT           = 0;
    localparam int unsigned FAULT_LO          = 2;
    localparam int unsigned FAULT_N           = 6;
    localparam int unsigned SYNC_BIT          = 7;
    localparam int unsigned CHECKSUM_BIT      = 6;
    localparam int unsigned UNCORR_BIT        = 5;
    localparam int unsigned CORR_BIT          = 4;
    localparam int unsigned PROTOCOL_BIT      = 3;
    localparam int unsigned LEADER_BIT        = 2;

    // Writable bits of each register
    localparam logic [7:0]  CTRL_WMASK        = 8'h01;
    localparam logic [7:0]  MASK_A_WMASK      = 8'hfd;
    localparam logic [7:0]  MASK_B_WMASK      = 8'hfc;

    // Reset values
    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [7:0]  MASK_RESET        = 8'h00;
    localparam logic        PLL_FLAG_RESET    = 1'h1;
    localparam logic        FAULT_FLAG_RESET  = 1'h0;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;

endpackage : dei_pkg

// ### dei_flag_bit.sv
// One sticky write-1-to-clear status flag
`timescale 1ns/100ps
module dei_flag_bit #(
    parameter logic RESET_VAL = 1'h0
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic set_in,
    input  wire logic clr_in,
    output logic      flag_out
);

    logic flag_reg;
    logic flag_next;

    // A set in the clearing cycle wins so no event is lost
    assign flag_next = set_in | (flag_reg & ~clr_in);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flag_reg <= RESET_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;

endmodule // dei_flag_bit

// ### dei_host_pin.sv
// Host side view of the three-state interrupt pin
`timescale 1ns/100ps
module dei_host_pin (
    input  wire logic clk_in,
    input  wire logic irq_in,
    input  wire logic irq_oe_in,
    output logic      pin_out
);
    logic last_reg = 1'h0;
    always_ff @(posedge clk_in) begin
        // Resolve to a level so a floating pin keeps toggling
        last_reg <= (pin_out === 1'h1);
    end
    // floating versus driven
    // No pull on this pin, so an undriven pin shows a changing level
    assign pin_out = irq_oe_in ? irq_in : ~last_reg;
endmodule // dei_host_pin

// ### tb.sv
// Self-checking bench for the error interrupt aggregator
`timescale 1ns/100ps
module tb;
    import dei_pkg::*;
    logic        clk_in = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, oe, pin;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [5:0]  fa = 6'h00, fb = 6'h00;
    logic        pll = 1'h1;
    logic [3:0]  strb = 4'hf;
    int          miscompares = 0;
    int          n_compared = 0;

    always #10 clk_in = ~clk_in;

    dei_irq_top uut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready),
        .chan_a_sync_fault_in(fa[5]), .chan_a_checksum_fault_in(fa[4]),
        .chan_a_uncorrectable_header_fault_in(fa[3]),
        .chan_a_corrected_header_fault_in(fa[2]),
        .chan_a_protocol_fault_in(fa[1]), .chan_a_leader_fault_in(fa[0]),
        .chan_b_sync_fault_in(fb[5]), .chan_b_checksum_fault_in(fb[4]),
        .chan_b_uncorrectable_header_fault_in(fb[3]),
        .chan_b_corrected_header_fault_in(fb[2]),
        .chan_b_protocol_fault_in(fb[1]), .chan_b_leader_fault_in(fb[0]),
        .pll_lock_in(pll), .irq_out(irq), .irq_oe_out(oe)
    );

    dei_host_pin host (.clk_in(clk_in), .irq_in(irq), .irq_oe_in(oe),
                       .pin_out(pin));

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic hung();
        miscompares++;
        $display("ERROR response expected 1 seen 0");
        end_sim();
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
            if (n > 40) hung();
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
            if (n > 40) hung();
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk("rdata", {24'h000000, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task automatic hit(input logic [5:0] a, b);
        @(posedge clk_in);
        fa <= a;
        fb <= b;
        @(posedge clk_in);
        fa <= 6'h00;
        fb <= 6'h00;
    endtask

    task automatic pin_is(input logic e);
        repeat (3) @(posedge clk_in);
        chk("irq_oe", 32'h1, {31'h0, oe});
        chk("irq_pin", {31'h0, e}, {31'h0, pin});
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("irq_oe", 32'h0, {31'h0, oe});
        rd(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
        rd(ADDR_CHAN_A_MASK, 8'h00, RESP_OKAY);
        rd(ADDR_CHAN_B_MASK, 8'h00, RESP_OKAY);
        rd(ADDR_CHAN_A_FLAGS, 8'h01, RESP_OKAY);
        rd(ADDR_CHAN_B_FLAGS, 8'h00, RESP_OKAY);
    endtask

    task automatic t_regs();
        wr(ADDR_CHAN_A_MASK, 8'hff, RESP_OKAY);
        rd(ADDR_CHAN_A_MASK, 8'hfd, RESP_OKAY);
        // Low byte lane off: the write is answered but changes nothing
        strb <= 4'he;
        wr(ADDR_CHAN_A_MASK, 8'h00, RESP_OKAY);
        strb <= 4'hf;
        rd(ADDR_CHAN_A_MASK, 8'hfd, RESP_OKAY);
        wr(ADDR_CHAN_B_MASK, 8'hff, RESP_OKAY);
        rd(ADDR_CHAN_B_MASK, 8'hfc, RESP_OKAY);
        wr(12'h000, 8'hff, RESP_SLVERR);
        rd(12'h000, 8'h00, RESP_SLVERR);
        wr(ADDR_CHAN_A_MASK, 8'h00, RESP_OKAY);
        wr(ADDR_CHAN_B_MASK, 8'h00, RESP_OKAY);
    endtask

    // Every fault source of both channels, set then cleared
    task automatic t_flags();
        logic [11:0] fl, ot;
        wr(ADDR_CHAN_A_FLAGS, 8'h01, RESP_OKAY);
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 6; i++) begin
                fl = c ? ADDR_CHAN_B_FLAGS : ADDR_CHAN_A_FLAGS;
                ot = c ? ADDR_CHAN_A_FLAGS : ADDR_CHAN_B_FLAGS;
                hit(c ? 6'h00 : 6'h01 << i, c ? 6'h01 << i : 6'h00);
                rd(fl, 8'h04 << i, RESP_OKAY);
                rd(ot, 8'h00, RESP_OKAY);
                wr(fl, ~(8'h04 << i), RESP_OKAY);
                rd(fl, 8'h04 << i, RESP_OKAY);
                wr(fl, 8'h04 << i, RESP_OKAY);
                rd(fl, 8'h00, RESP_OKAY);
            end
        end
    endtask

    task automatic t_irq();
        wr(ADDR_IRQ_CTRL, 8'h01, RESP_OKAY);
        pin_is(1'h0);
        hit(6'h00, 6'h20);
        pin_is(1'h0);
        wr(ADDR_CHAN_B_MASK, 8'h80, RESP_OKAY);
        pin_is(1'h1);
        wr(ADDR_IRQ_CTRL, 8'h00, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        chk("irq_oe", 32'h0, {31'h0, oe});
        wr(ADDR_IRQ_CTRL, 8'h01, RESP_OKAY);
        pin_is(1'h1);
        wr(ADDR_CHAN_B_FLAGS, 8'h80, RESP_OKAY);
        pin_is(1'h0);
        wr(ADDR_CHAN_B_MASK, 8'h00, RESP_OKAY);
    endtask

    task automatic t_pll();
        wr(ADDR_CHAN_A_MASK, 8'h01, RESP_OKAY);
        pin_is(1'h0);
        pll <= 1'h0;
        repeat (6) @(posedge clk_in);
        pin_is(1'h1);
        rd(ADDR_CHAN_A_FLAGS, 8'h01, RESP_OKAY);
        pll <= 1'h1;
        wr(ADDR_CHAN_A_FLAGS, 8'h01, RESP_OKAY);
        pin_is(1'h0);
        // Channel A fault masked, then let through
        hit(6'h01, 6'h00);
        pin_is(1'h0);
        wr(ADDR_CHAN_A_MASK, 8'h04, RESP_OKAY);
        pin_is(1'h1);
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        repeat (2) @(posedge clk_in);
        t_reset();
        t_regs();
        t_flags();
        t_irq();
        t_pll();
        end_sim();
    end
endmodule // tb
